// [design/fwg_guard.sv]
// Flash write and erase guard: key machine, operation sequencer, page security.
// Assumes flash array acts on one-cycle strobes and the core honours the stall.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module fwg_guard
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire fwg_pkg::fwg_req_type  core_req,
  input  wire logic [15:0]           core_pc,
  input  wire fwg_pkg::fwg_req_type  dbg_req,
  input  wire logic                  dbg_device_erase,
  input  wire logic [7:0]            lock_byte,
  input  wire logic                  ferr_seen_at_boot,
  output logic                       core_stall,
  output logic                       ram_write,
  output logic                       ram_read,
  output logic                       flash_read,
  output logic                       dbg_refused,
  output logic                       ferr_reset,
  output fwg_pkg::fwg_flash_type     flash_cmd
);

  // ==========================================================
  // Security decode
  fwg_pkg::fwg_state_type s_reg;
  fwg_pkg::fwg_state_type s_next;
  localparam int TIMER_W = fwg_pkg::TIMER_W;
  logic [7:0] locked_n;
  logic       lockp_locked;
  logic       pc_locked;
  logic [6:0] tgt_page;
  logic       tgt_reserved;
  logic       tgt_lockpage;
  logic       tgt_locked;
  logic       fw_allowed;
  logic       dbg_allowed;
  logic       op_erase;
  logic       bus_wr;
  logic       bus_rd;
  logic       flash_wr;

  // Full 8-bit page count, so a count above 127 still locks every page
  assign locked_n     = ~lock_byte;
  assign lockp_locked = (lock_byte != fwg_pkg::ERASED_BYTE);
  assign pc_locked    = ({1'b0, core_pc[15:fwg_pkg::PAGE_BITS]} < locked_n);
  assign tgt_page     = core_req.addr[15:fwg_pkg::PAGE_BITS];
  assign tgt_reserved = (core_req.addr > fwg_pkg::USER_TOP);
  assign tgt_lockpage = (tgt_page == fwg_pkg::LOCK_PAGE);
  assign tgt_locked   = tgt_lockpage ? lockp_locked : ({1'b0, tgt_page} < locked_n);
  assign op_erase     = s_reg.store_ee;
  assign flash_wr     = core_req.valid && core_req.write && s_reg.store_we;

  // Firmware access check
  always_comb
  begin
    fw_allowed = 1'b1;
    if (tgt_reserved)
      fw_allowed = 1'b0;
    else if (tgt_lockpage && flash_wr && op_erase)
      fw_allowed = 1'b0;
    else if (tgt_lockpage && flash_wr && core_req.addr == fwg_pkg::LOCK_ADDR
             && (core_req.data & ~lock_byte) != 8'h00)
      fw_allowed = 1'b0;
    else if (tgt_lockpage && !(core_req.code_read && core_req.addr == fwg_pkg::LOCK_ADDR))
      fw_allowed = pc_locked || !lockp_locked;
    else if (tgt_locked && !tgt_lockpage)
      fw_allowed = pc_locked;
  end

  // Debug port check
  always_comb
  begin
    logic [6:0] dpage;
    dpage = dbg_req.addr[15:fwg_pkg::PAGE_BITS];
    dbg_allowed = 1'b1;
    if (dbg_req.addr > fwg_pkg::USER_TOP)
      dbg_allowed = 1'b0;
    else if (!dbg_req.write && dbg_req.addr == fwg_pkg::LOCK_ADDR)
      dbg_allowed = 1'b1;
    else if (dbg_req.write && dbg_req.addr == fwg_pkg::LOCK_ADDR
             && (dbg_req.data & ~lock_byte) == 8'h00)
      dbg_allowed = 1'b1;
    else if (dpage == fwg_pkg::LOCK_PAGE)
      dbg_allowed = !lockp_locked;
    else if ({1'b0, dpage} < locked_n)
      dbg_allowed = 1'b0;
  end

  assign bus_wr = psel && penable && pwrite;
  assign bus_rd = psel && !pwrite;

  // ==========================================================
  // Next state
  always_comb
  begin
    s_next = s_reg;
    s_next.flash.prog  = 1'b0;
    s_next.flash.erase = 1'b0;
    s_next.ferr_reset  = 1'b0;
    s_next.ram_wr      = 1'b0;
    if (bus_wr && paddr == fwg_pkg::ADDR_STORE)
    begin
      s_next.store_we = pwdata[fwg_pkg::STORE_WE_BIT];
      s_next.store_ee = pwdata[fwg_pkg::STORE_EE_BIT];
    end
    if (bus_wr && paddr == fwg_pkg::ADDR_FETCH)
      s_next.two_sel = pwdata[fwg_pkg::FETCH_TWO_BIT];
    if (bus_wr && paddr == fwg_pkg::ADDR_RST_SRC && !pwdata[fwg_pkg::RST_FERR_BIT])
      s_next.ferr_flag = 1'b0;
    if (ferr_seen_at_boot)
      s_next.ferr_flag = 1'b1;
    if (bus_wr && paddr == fwg_pkg::ADDR_KEY)
    begin
      case (s_reg.key)
        fwg_pkg::KEY_IDLE:
          s_next.key = (pwdata[7:0] == fwg_pkg::KEY_FIRST) ?
                       fwg_pkg::KEY_FIRSTSN : fwg_pkg::KEY_LOCKOUT;
        fwg_pkg::KEY_FIRSTSN:
          s_next.key = (pwdata[7:0] == fwg_pkg::KEY_SECOND) ?
                       fwg_pkg::KEY_ARMED : fwg_pkg::KEY_LOCKOUT;
        fwg_pkg::KEY_ARMED:
          s_next.key = fwg_pkg::KEY_LOCKOUT;
        fwg_pkg::KEY_LOCKOUT:
          s_next.key = fwg_pkg::KEY_LOCKOUT;
        default:
          s_next.key = fwg_pkg::KEY_LOCKOUT;
      endcase
    end
    if (bus_rd)
    begin
      case (paddr)
        fwg_pkg::ADDR_STORE:  s_next.prdata = 32'({s_reg.store_ee, s_reg.store_we});
        fwg_pkg::ADDR_FETCH:  s_next.prdata = 32'(s_reg.two_sel) << fwg_pkg::FETCH_TWO_BIT;
        fwg_pkg::ADDR_RST_SRC: s_next.prdata = 32'(s_reg.ferr_flag) << fwg_pkg::RST_FERR_BIT;
        fwg_pkg::ADDR_STATUS: s_next.prdata = 32'({s_reg.op, s_reg.key});
        default:              s_next.prdata = 32'h0000_0000;
      endcase
    end
    if (core_req.valid && core_req.write && !s_reg.store_we)
      s_next.ram_wr = 1'b1;
    case (s_reg.op)
      fwg_pkg::OP_IDLE:
      begin
        if (core_req.valid && !fw_allowed && (flash_wr || core_req.code_read))
        begin
          s_next.ferr_reset = 1'b1;
          s_next.ferr_flag  = 1'b1;
        end
        else if (flash_wr && s_reg.key != fwg_pkg::KEY_ARMED)
          s_next.key = fwg_pkg::KEY_LOCKOUT;
        else if (flash_wr)
        begin
          s_next.flash.addr = core_req.addr;
          if (s_reg.store_ee)
          begin
            s_next.key         = fwg_pkg::KEY_IDLE;
            s_next.flash.erase = 1'b1;
            s_next.flash.two   = 1'b0;
            s_next.flash.data  = {2{fwg_pkg::ERASED_BYTE}};
            s_next.op          = fwg_pkg::OP_ERASE;
            s_next.timer       = TIMER_W'(fwg_pkg::ERASE_CYCLES);
          end
          else if (s_reg.two_sel && !core_req.addr[0])
          begin
            s_next.key       = fwg_pkg::KEY_IDLE;
            s_next.even_held = 1'b1;
            s_next.even_data = core_req.data;
          end
          else
          begin
            s_next.key        = fwg_pkg::KEY_IDLE;
            s_next.flash.prog = 1'b1;
            s_next.flash.two  = s_reg.two_sel && s_reg.even_held;
            s_next.flash.data = {core_req.data,
                                 s_reg.two_sel ? s_reg.even_data : fwg_pkg::ERASED_BYTE};
            s_next.even_held  = 1'b0;
            s_next.op         = fwg_pkg::OP_PROG;
            s_next.timer      = TIMER_W'(fwg_pkg::WRITE_CYCLES);
          end
        end
      end
      fwg_pkg::OP_PROG, fwg_pkg::OP_ERASE:
      begin
        s_next.timer = s_reg.timer - 1'b1;
        if (s_reg.timer == TIMER_W'(1))
          s_next.op = fwg_pkg::OP_IDLE;
      end
      default:
        s_next.op = fwg_pkg::OP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg       <= '0;
      s_reg.key   <= fwg_pkg::KEY_IDLE;
      s_reg.op    <= fwg_pkg::OP_IDLE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata      = s_reg.prdata;
  assign pready      = 1'b1;
  assign pslverr     = 1'b0;
  assign core_stall  = (s_reg.op != fwg_pkg::OP_IDLE);
  assign ram_write   = s_reg.ram_wr;
  assign ram_read    = core_req.valid && !core_req.write && !core_req.code_read;
  assign flash_read  = core_req.valid && core_req.code_read && fw_allowed;
  assign dbg_refused = dbg_req.valid && !dbg_allowed && !dbg_device_erase;
  assign ferr_reset  = s_reg.ferr_reset;
  assign flash_cmd   = s_reg.flash;

  // ==========================================================
  // Checks
  property p_stall_len;
    @(posedge pclk) disable iff (!presetn)
    $rose(s_reg.flash.prog) |-> core_stall [*8];
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall too short");

  property p_key_relock;
    @(posedge pclk) disable iff (!presetn)
    (s_reg.flash.prog || s_reg.flash.erase) |-> s_reg.key != fwg_pkg::KEY_ARMED;
  endproperty
  a_key_relock: assert property (p_key_relock) else $error("key stayed armed");

  property p_lockout_sticks;
    @(posedge pclk) disable iff (!presetn)
    s_reg.key == fwg_pkg::KEY_LOCKOUT |=> s_reg.key == fwg_pkg::KEY_LOCKOUT;
  endproperty
  a_lockout_sticks: assert property (p_lockout_sticks) else $error("lockout left");

  property p_no_op_locked;
    @(posedge pclk) disable iff (!presetn)
    s_reg.key == fwg_pkg::KEY_LOCKOUT |=> !s_reg.flash.prog && !s_reg.flash.erase;
  endproperty
  a_no_op_locked: assert property (p_no_op_locked) else $error("op in lockout");

  property p_erase_ff;
    @(posedge pclk) disable iff (!presetn)
    s_reg.flash.erase |-> s_reg.flash.data == {2{fwg_pkg::ERASED_BYTE}};
  endproperty
  a_erase_ff: assert property (p_erase_ff) else $error("erase data not ones");

  sequence s_err_then_flag;
    ferr_reset ##1 s_reg.ferr_flag;
  endsequence

  property p_reserved_err;
    @(posedge pclk) disable iff (!presetn)
    (flash_wr && tgt_reserved && !core_stall) |=> s_err_then_flag;
  endproperty
  a_reserved_err: assert property (p_reserved_err) else $error("no error reset");

  property p_ram_read;
    @(posedge pclk) disable iff (!presetn)
    (core_req.valid && !core_req.write && !core_req.code_read) |->
      ram_read && !flash_read ##1 !s_reg.flash.prog && !s_reg.flash.erase;
  endproperty
  a_ram_read: assert property (p_ram_read) else $error("move read hit flash");

  property p_erase_needs_ee;
    @(posedge pclk) disable iff (!presetn)
    $rose(s_reg.flash.erase) |-> $past(s_reg.store_ee) && $past(s_reg.store_we);
  endproperty
  a_erase_needs_ee: assert property (p_erase_needs_ee) else $error("erase without enables");

endmodule

// [pkg/fwg_pkg.sv]
// Constants, types and register map for the flash write and erase guard.
// Assumes an APB master in the pclk domain and a flash array behind simple strobes.
//
// Summary of operation
// - Program clears bits; erase sets whole page 0xff
// - Time operations internally, stall core until done
// - Key 0xa5 then 0xf1 arms operations
// - Wrong key value or order locks out
// - Operation attempted unarmed locks out until reset
// - Key relocks after every operation
// - Store write enable steers moves to flash
// - Erase enable write erases whole page
// - Writes need write enable; erase needs both
// - Select bit picks byte or two-byte mode
// - Byte mode programs after each move write
// - Even byte then odd; program after odd
// - Block program takes byte program time
// - Move reads go to RAM, never flash
// - Lock byte complement counts locked pages
// - Lock page locked when lock byte not ones
// - Debug port limited to unlocked pages
// - Unlocked code: no locked pages or unlock
// - Locked code: all but lock erase, reserved; code also refuses lock byte writes that set bits
// - Forbidden access raises flash error reset
// - Error flag reads one after error reset
// - Write above user space raises error reset
package fwg_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] ADDR_KEY     = 12'h000;
  localparam logic [11:0] ADDR_STORE   = 12'h004;
  localparam logic [11:0] ADDR_FETCH   = 12'h008;
  localparam logic [11:0] ADDR_RST_SRC = 12'h00c;
  localparam logic [11:0] ADDR_STATUS  = 12'h010;

  localparam int STORE_WE_BIT  = 0;
  localparam int STORE_EE_BIT  = 1;
  localparam int FETCH_TWO_BIT = 5;
  localparam int RST_FERR_BIT  = 6;

  // ==========================================================
  // Flash geometry and constants
  localparam logic [7:0]  KEY_FIRST   = 8'ha5;
  localparam logic [7:0]  KEY_SECOND  = 8'hf1;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam int          PAGE_BITS   = 9;
  localparam logic [15:0] USER_TOP    = 16'h7dff;
  localparam logic [15:0] LOCK_ADDR   = 16'h7dff;
  localparam logic [6:0]  LOCK_PAGE   = 7'h3e;

  // ==========================================================
  // Timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int WRITE_TIME_NS = 1000;
  localparam int ERASE_TIME_US = 20;
  localparam int WRITE_CYCLES  = (WRITE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int ERASE_CYCLES  = ERASE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int TIMER_W       = 16;

  typedef enum logic [3:0] {
    KEY_IDLE    = 4'b0001,
    KEY_FIRSTSN = 4'b0010,
    KEY_ARMED   = 4'b0100,
    KEY_LOCKOUT = 4'b1000
  } fwg_key_type;

  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_PROG  = 3'b010,
    OP_ERASE = 3'b100
  } fwg_op_type;

  // Request from the core or debug port
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        code_read;
    logic [15:0] addr;
    logic [7:0]  data;
  } fwg_req_type;

  // Command to the flash array
  typedef struct packed {
    logic        prog;
    logic        erase;
    logic        two;
    logic [15:0] addr;
    logic [15:0] data;
  } fwg_flash_type;

  typedef struct packed {
    fwg_key_type   key;
    fwg_op_type    op;
    logic [TIMER_W-1:0] timer;
    logic          store_we;
    logic          store_ee;
    logic          two_sel;
    logic          even_held;
    logic [7:0]    even_data;
    logic          ferr_flag;
    logic          ferr_reset;
    logic          ram_wr;
    fwg_flash_type flash;
    logic [31:0]   prdata;
  } fwg_state_type;

endpackage

// [verif/fwg_core_model.sv]
// Behavioural processor core and debug port on the far side of the guard.
// Assumes the bench calls its tasks from the pclk domain only.
`timescale 1ns/1ns
module fwg_core_model
(
  input  wire logic            pclk,
  output fwg_pkg::fwg_req_type core_req,
  output fwg_pkg::fwg_req_type dbg_req,
  output logic [15:0]          core_pc,
  output logic                 dbg_device_erase,
  output logic [7:0]           lock_byte
);
  // ==========================================================
  // Idle values
  initial
  begin
    core_req = '0;
    dbg_req = '0;
    core_pc = 16'h0000;
    dbg_device_erase = 1'b0;
    lock_byte = 8'hff;
  end

  // ==========================================================
  // Requests: one cycle per instruction, raised after an edge
  task automatic go(input logic dbg, wr, cd, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    if (dbg)
      dbg_req <= {1'b1, wr, cd, a, d};
    else
      core_req <= {1'b1, wr, cd, a, d};
  endtask

  // Released lines show the inverse of the last value
  task automatic rel();
    core_req <= {3'b000, ~core_req.addr, ~core_req.data};
    dbg_req <= {3'b000, ~dbg_req.addr, ~dbg_req.data};
  endtask

  task automatic env(input logic [15:0] pc, input logic [7:0] lk, input logic de);
    @(posedge pclk);
    core_pc <= pc;
    lock_byte <= lk;
    dbg_device_erase <= de;
  endtask
endmodule

// [verif/fwg_guard_test.sv]
// Self-checking bench for the flash write and erase guard.
// Assumes the core model drives requests and APB reaches the registers.
`timescale 1ns/1ns
module fwg_guard_test;
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  ferr_seen_at_boot;
  logic                  core_stall;
  logic                  ram_write;
  logic                  ram_read;
  logic                  flash_read;
  logic                  dbg_refused;
  logic                  ferr_reset;
  logic [15:0]           core_pc;
  logic                  dbg_device_erase;
  logic [7:0]            lock_byte;
  fwg_pkg::fwg_req_type  core_req;
  fwg_pkg::fwg_req_type  dbg_req;
  fwg_pkg::fwg_flash_type flash_cmd;
  int                    n_errors;
  int                    num_checks;
  int                    sn;
  logic [31:0]           rd;

  typedef struct packed {
    logic dbg; logic de; logic [15:0] pc; logic [7:0] lk; logic [15:0] a; logic ex;
  } fwg_case_type;
  localparam fwg_case_type CASES [12] = '{
    '{1'b0,1'b0,16'h1000,8'hfe,16'h0010,1'b1}, '{1'b0,1'b0,16'h0000,8'hfe,16'h0010,1'b0},
    '{1'b0,1'b0,16'h1000,8'hfe,16'h7e10,1'b1}, '{1'b0,1'b0,16'h1000,8'hfd,16'h0210,1'b1},
    '{1'b0,1'b0,16'h1000,8'hfe,16'h0410,1'b0}, '{1'b0,1'b0,16'h1000,8'hff,16'h7c10,1'b0},
    '{1'b0,1'b0,16'h1000,8'hfe,16'h7c10,1'b1}, '{1'b0,1'b0,16'h1000,8'hfe,16'h7dff,1'b0},
    '{1'b1,1'b0,16'h0000,8'hfe,16'h0010,1'b1}, '{1'b1,1'b0,16'h0000,8'hfe,16'h0410,1'b0},
    '{1'b1,1'b0,16'h0000,8'hfe,16'h7dff,1'b0}, '{1'b1,1'b1,16'h0000,8'hfe,16'h0010,1'b0}};

  fwg_guard u_fwg_guard (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_req(core_req), .core_pc(core_pc), .dbg_req(dbg_req),
    .dbg_device_erase(dbg_device_erase), .lock_byte(lock_byte),
    .ferr_seen_at_boot(ferr_seen_at_boot), .core_stall(core_stall), .ram_write(ram_write),
    .ram_read(ram_read), .flash_read(flash_read), .dbg_refused(dbg_refused),
    .ferr_reset(ferr_reset), .flash_cmd(flash_cmd));
  fwg_core_model u_fwg_core_model (.pclk(pclk), .core_req(core_req), .dbg_req(dbg_req),
    .core_pc(core_pc), .dbg_device_erase(dbg_device_erase), .lock_byte(lock_byte));

  // ==========================================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    {psel, penable} <= 2'b00;
    #1 rd = prdata;
    if (n >= 16)
    begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic key();
    apb(1'b1, fwg_pkg::ADDR_KEY, {24'h0, fwg_pkg::KEY_FIRST});
    apb(1'b1, fwg_pkg::ADDR_KEY, {24'h0, fwg_pkg::KEY_SECOND});
  endtask

  // Move write; checks strobes, error pulse, address, data, then counts stall
  task automatic mv(input logic [15:0] a, input logic [7:0] d, input logic p, e, f,
                    input logic [15:0] ed, m);
    u_fwg_core_model.go(1'b0, 1'b1, 1'b0, a, d);
    @(posedge pclk);
    u_fwg_core_model.rel();
    #1 check(flash_cmd.prog, p, "prog strobe");
    check(flash_cmd.erase, e, "erase strobe");
    check(ferr_reset, f, "error reset");
    if (p | e)
      check(flash_cmd.addr[15:9], a[15:9], "page");
    if (p)
      check(flash_cmd.data & m, ed & m, "data");
    sn = 0;
    while (core_stall === 1'b1 && sn < 2000)
    begin
      @(posedge pclk);
      #1 sn++;
    end
    if (sn >= 2000)
    begin
      n_errors++;
      conclude();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_byte();
    rst();
    apb(1'b1, fwg_pkg::ADDR_STORE, 32'h1);
    apb(1'b1, fwg_pkg::ADDR_FETCH, 32'h0);
    key();
    mv(16'h1234, 8'h5a, 1'b1, 1'b0, 1'b0, 16'h5aff, 16'hffff);
    check(sn, fwg_pkg::WRITE_CYCLES, "write stall");
    mv(16'h1236, 8'h00, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
    key();
    mv(16'h1238, 8'h00, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
    $display("t_byte done");
  endtask

  task automatic t_block();
    rst();
    apb(1'b1, fwg_pkg::ADDR_STORE, 32'h1);
    apb(1'b1, fwg_pkg::ADDR_FETCH, 32'h20);
    key();
    mv(16'h0100, 8'hff, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
    key();
    mv(16'h0101, 8'h22, 1'b1, 1'b0, 1'b0, 16'h22ff, 16'hffff);
    check(flash_cmd.two, 1'b1, "two-byte");
    check(sn, fwg_pkg::WRITE_CYCLES, "block stall");
    $display("t_block done");
  endtask

  task automatic t_erase();
    rst();
    apb(1'b1, fwg_pkg::ADDR_STORE, 32'h3);
    key();
    mv(16'h0456, 8'h00, 1'b0, 1'b1, 1'b0, 16'h0, 16'h0);
    check(sn, fwg_pkg::ERASE_CYCLES, "erase stall");
    key();
    mv(16'h7e00, 8'h00, 1'b0, 1'b0, 1'b1, 16'h0, 16'h0);
    apb(1'b0, fwg_pkg::ADDR_RST_SRC, 32'h0);
    check(rd[fwg_pkg::RST_FERR_BIT], 1'b1, "error flag set");
    apb(1'b1, fwg_pkg::ADDR_RST_SRC, 32'h0);
    apb(1'b0, fwg_pkg::ADDR_RST_SRC, 32'h0);
    check(rd[fwg_pkg::RST_FERR_BIT], 1'b0, "error flag clear");
    $display("t_erase done");
  endtask

  task automatic t_misc();
    rst();
    apb(1'b1, fwg_pkg::ADDR_STORE, 32'h1);
    apb(1'b1, fwg_pkg::ADDR_KEY, {24'h0, fwg_pkg::KEY_SECOND});
    key();
    mv(16'h0020, 8'h33, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
    apb(1'b1, fwg_pkg::ADDR_STORE, 32'h0);
    u_fwg_core_model.go(1'b0, 1'b1, 1'b0, 16'h0040, 8'h44);
    @(posedge pclk);
    u_fwg_core_model.rel();
    #1 check(ram_write, 1'b1, "ram write");
    check(flash_cmd.prog, 1'b0, "no prog");
    u_fwg_core_model.go(1'b0, 1'b0, 1'b0, 16'h0040, 8'h00);
    #1 check({ram_read, flash_read}, 2'b10, "move read");
    @(posedge pclk);
    u_fwg_core_model.rel();
    ferr_seen_at_boot <= 1'b1;
    @(posedge pclk);
    ferr_seen_at_boot <= 1'b0;
    apb(1'b0, fwg_pkg::ADDR_RST_SRC, 32'h0);
    check(rd[fwg_pkg::RST_FERR_BIT], 1'b1, "error flag");
    apb(1'b0, 12'h0fc, 32'h0);
    check(pslverr, 1'b0, "unmapped error");
    check(rd, 32'h0, "unmapped");
    $display("t_misc done");
  endtask

  task automatic t_sec();
    fwg_case_type c;
    rst();
    for (int i = 0; i < 12; i++)
    begin
      c = CASES[i];
      u_fwg_core_model.env(c.pc, c.lk, c.de);
      u_fwg_core_model.go(c.dbg, 1'b0, 1'b1, c.a, 8'h00);
      #1 if (c.dbg)
        check(dbg_refused, c.ex, "debug refusal");
      else
        check(flash_read, !c.ex, "code read");
      @(posedge pclk);
      u_fwg_core_model.rel();
      #1 if (!c.dbg)
        check(ferr_reset, c.ex, "error reset");
    end
    $display("t_sec done");
  endtask

  // ==========================================================
  // Clock and main sequence
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ferr_seen_at_boot} = '0;
    n_errors = 0;
    num_checks = 0;
    t_byte();
    t_block();
    t_erase();
    t_misc();
    t_sec();
    conclude();
  end
endmodule
